// ### verilog/uac_map.svh
`ifndef UAC_MAP_SVH
`define UAC_MAP_SVH

// clock rate in MHz
`define UAC_CLK_MHZ 250
// glitch filter settle time on supply sense and host select, ns
`define UAC_FILT_NS 1000
`define UAC_FILT_CYC ((`UAC_FILT_NS * `UAC_CLK_MHZ + 999) / 1000)
// bus idle time before suspend, us
`define UAC_SUSP_IDLE_US 3000
`define UAC_SUSP_IDLE_CYC (`UAC_SUSP_IDLE_US * `UAC_CLK_MHZ)
// least time suspended before remote wake may be signalled, us
`define UAC_RWAKE_MIN_US 5000
`define UAC_RWAKE_MIN_CYC (`UAC_RWAKE_MIN_US * `UAC_CLK_MHZ)
// length of remote wake signalling, us
`define UAC_RESUME_US 2000
`define UAC_RESUME_CYC (`UAC_RESUME_US * `UAC_CLK_MHZ)
// width of the shared timing counter
`define UAC_CNT_W 21
// width of the glitch filter counter
`define UAC_FCNT_W 8
// serial ports offered by the default profile
`define UAC_ACM_PORTS 3'h6
// no ports in the initial profile
`define UAC_NO_PORTS 3'h0
// data path shape
`define UAC_DATA_W 8
`define UAC_FIFO_DEPTH 8
`define UAC_FIFO_AW 3
// positions in the sensed pin vector
`define UAC_PIN_SUPPLY 0
`define UAC_PIN_HSEL 1
`define UAC_PIN_STRB 2
`define UAC_PIN_DATA 3
`define UAC_PIN_N 4
`define UAC_FILT_N 2

`endif

// ### verilog/uac_pkg.sv
package uac_pkg;

  // attach and power state of the function
  typedef enum logic [1:0] {
    UAC_ST_OFF  = 2'h0,
    UAC_ST_RUN  = 2'h1,
    UAC_ST_SUSP = 2'h2,
    UAC_ST_WAKE = 2'h3
  } uac_state_t;

endpackage : uac_pkg

// ### verilog/uac_attach_ctl.sv
`timescale 1ns/1ps
`include "uac_map.svh"

module uac_fifo #(
  parameter int WIDTH = `UAC_DATA_W,
  parameter int DEPTH = `UAC_FIFO_DEPTH,
  parameter int AW = `UAC_FIFO_AW
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  // handshakes on both sides
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_q[rd_q];

  // occupancy after this cycle
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end

  // storage array
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers, count and registered full and empty
  always_ff @(posedge clock) begin
    if (sys_rst || clear) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == LAST) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != FULL_CNT);
      out_valid <= (cnt_d != '0);
    end
  end
endmodule : uac_fifo

module uac_attach_ctl #(
  parameter int SUSP_IDLE_CYC = `UAC_SUSP_IDLE_CYC,
  parameter int RWAKE_MIN_CYC = `UAC_RWAKE_MIN_CYC,
  parameter int RESUME_CYC = `UAC_RESUME_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic bus_supply_sense,
  input wire logic host_select,
  input wire logic interchip_ddr_data_in,
  output logic interchip_ddr_data_out,
  output logic interchip_ddr_data_oe_n,
  input wire logic interchip_strobe_in,
  output logic interchip_strobe_out,
  output logic interchip_strobe_oe_n,
  input wire logic line_activity,
  input wire logic port_disabled,
  input wire logic profile_switch,
  input wire logic remote_wake_allowed,
  input wire logic wake_event,
  input wire logic power_saving_setting,
  input wire logic [`UAC_DATA_W-1:0] user_tx_data,
  input wire logic user_tx_valid,
  output logic user_tx_ready,
  output logic [`UAC_DATA_W-1:0] link_tx_data,
  output logic link_tx_valid,
  input wire logic link_tx_ready,
  output logic usb_enable,
  output logic interchip_mode,
  output logic profile_default,
  output logic [2:0] acm_port_count,
  output logic suspended,
  output logic low_power_idle,
  output logic resume_drive,
  output logic others_power_saving
);
  localparam int CW = `UAC_CNT_W;
  localparam int FW = `UAC_FCNT_W;
  localparam logic [CW-1:0] SUSP_LIM = CW'(SUSP_IDLE_CYC - 1);
  localparam logic [CW-1:0] RWAKE_LIM = CW'(RWAKE_MIN_CYC - 1);
  localparam logic [CW-1:0] RESUME_LIM = CW'(RESUME_CYC - 1);
  localparam logic [FW-1:0] FILT_LIM = FW'(`UAC_FILT_CYC - 1);
  uac_pkg::uac_state_t state_q;
  logic [`UAC_PIN_N-1:0] pin_raw;
  logic [`UAC_PIN_N-1:0] meta_q;
  logic [`UAC_PIN_N-1:0] sync_q;
  logic [`UAC_FILT_N-1:0] filt_q;
  logic [`UAC_FILT_N-1:0] filt_prev_q;
  logic strb_prev_q;
  logic data_prev_q;
  logic [CW-1:0] cnt_q;
  logic wake_pend_q;
  logic activity;
  logic supply_fall;
  logic hsel_fall;
  logic attach_req;
  logic detach;
  logic link_up;
  logic [`UAC_DATA_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic out_free;

  assign pin_raw = {interchip_ddr_data_in, interchip_strobe_in,
                    host_select, bus_supply_sense};

  // two stage synchronisers for every sensed pin
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
    end
  end

  // level filters on supply sense and host select
  generate
    for (genvar i = 0; i < `UAC_FILT_N; i++) begin : g_filt
      logic [FW-1:0] fcnt_q;
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          fcnt_q <= '0;
          filt_q[i] <= 1'b0;
        end else if (sync_q[i] == filt_q[i]) begin
          fcnt_q <= '0;
        end else if (fcnt_q == FILT_LIM) begin
          fcnt_q <= '0;
          filt_q[i] <= sync_q[i];
        end else begin
          fcnt_q <= fcnt_q + FW'(1);
        end
      end
    end
  endgenerate

  // edge history of filtered levels and of the link pins
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      filt_prev_q <= '0;
      strb_prev_q <= 1'b0;
      data_prev_q <= 1'b0;
    end else begin
      filt_prev_q <= filt_q;
      strb_prev_q <= sync_q[`UAC_PIN_STRB];
      data_prev_q <= sync_q[`UAC_PIN_DATA];
    end
  end

  // attach, detach and activity decode
  assign supply_fall = filt_prev_q[`UAC_PIN_SUPPLY] &
                       !filt_q[`UAC_PIN_SUPPLY];
  assign hsel_fall = filt_prev_q[`UAC_PIN_HSEL] & !filt_q[`UAC_PIN_HSEL];
  // inter-chip link is chosen and connected by host select
  assign attach_req = filt_q[`UAC_PIN_SUPPLY] | filt_q[`UAC_PIN_HSEL];
  assign detach = interchip_mode ? hsel_fall : supply_fall;
  // strobe or data transitions mark traffic on the inter-chip link
  assign activity = interchip_mode ?
                    ((sync_q[`UAC_PIN_STRB] ^ strb_prev_q) |
                     (sync_q[`UAC_PIN_DATA] ^ data_prev_q)) :
                    line_activity;

  // main attach and power state machine
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= uac_pkg::UAC_ST_OFF;
      cnt_q <= '0;
    end else if (detach && state_q != uac_pkg::UAC_ST_OFF) begin
      state_q <= uac_pkg::UAC_ST_OFF;
      cnt_q <= '0;
    end else begin
      case (state_q)
        uac_pkg::UAC_ST_OFF: begin
          cnt_q <= '0;
          if (attach_req) begin
            state_q <= uac_pkg::UAC_ST_RUN;
          end
        end
        uac_pkg::UAC_ST_RUN: begin
          if (activity && !port_disabled) begin // disabled port wins
            cnt_q <= '0;
          end else if (port_disabled || cnt_q == SUSP_LIM) begin
            state_q <= uac_pkg::UAC_ST_SUSP;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + CW'(1);
          end
        end
        uac_pkg::UAC_ST_SUSP: begin
          if (activity && !port_disabled) begin
            state_q <= uac_pkg::UAC_ST_RUN;
            cnt_q <= '0;
          end else if (cnt_q != RWAKE_LIM) begin
            cnt_q <= cnt_q + CW'(1);
          end else if (wake_pend_q && remote_wake_allowed) begin
            state_q <= uac_pkg::UAC_ST_WAKE;
            cnt_q <= '0;
          end
        end
        uac_pkg::UAC_ST_WAKE: begin
          if (cnt_q == RESUME_LIM) begin
            state_q <= uac_pkg::UAC_ST_SUSP;
            cnt_q <= RWAKE_LIM;
          end else begin
            cnt_q <= cnt_q + CW'(1);
          end
        end
        default: begin
          state_q <= uac_pkg::UAC_ST_OFF;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // pending internal wake reason; a new event wins over the clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wake_pend_q <= 1'b0;
    end else if (wake_event) begin
      wake_pend_q <= 1'b1;
    end else if (state_q == uac_pkg::UAC_ST_WAKE ||
                 state_q == uac_pkg::UAC_ST_RUN ||
                 state_q == uac_pkg::UAC_ST_OFF) begin
      wake_pend_q <= 1'b0;
    end
  end

  // mode latched on attach, profile kept across suspend
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      interchip_mode <= 1'b0;
      profile_default <= 1'b0;
      acm_port_count <= `UAC_NO_PORTS;
    end else if (state_q == uac_pkg::UAC_ST_OFF) begin
      // supply sense takes precedence when both are present
      interchip_mode <= !filt_q[`UAC_PIN_SUPPLY] &
                        filt_q[`UAC_PIN_HSEL];
      profile_default <= 1'b0;
      acm_port_count <= `UAC_NO_PORTS;
    end else if (profile_switch && state_q == uac_pkg::UAC_ST_RUN) begin
      profile_default <= 1'b1;
      acm_port_count <= `UAC_ACM_PORTS;
    end
  end

  // status outputs
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      usb_enable <= 1'b0;
      suspended <= 1'b0;
      low_power_idle <= 1'b0;
      resume_drive <= 1'b0;
      others_power_saving <= 1'b0;
    end else begin
      usb_enable <= (state_q != uac_pkg::UAC_ST_OFF);
      suspended <= (state_q == uac_pkg::UAC_ST_SUSP) ||
                   (state_q == uac_pkg::UAC_ST_WAKE);
      // never idle while running, whatever the setting says
      low_power_idle <= (state_q == uac_pkg::UAC_ST_SUSP) &&
                        power_saving_setting && !wake_pend_q &&
                        !wake_event && !activity;
      resume_drive <= (state_q == uac_pkg::UAC_ST_WAKE) &&
                      !interchip_mode;
      others_power_saving <= power_saving_setting;
    end
  end

  // inter-chip pins: released except while signalling remote wake in inter-chip mode
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      interchip_ddr_data_out <= 1'b0;
      interchip_ddr_data_oe_n <= 1'b1;
      interchip_strobe_out <= 1'b0;
      interchip_strobe_oe_n <= 1'b1;
    end else begin
      interchip_ddr_data_out <= 1'b1;
      interchip_strobe_out <= 1'b0;
      interchip_ddr_data_oe_n <= !(interchip_mode &&
                                   state_q == uac_pkg::UAC_ST_WAKE);
      interchip_strobe_oe_n <= !(interchip_mode &&
                                 state_q == uac_pkg::UAC_ST_WAKE);
    end
  end

  // data moves only with the default profile and an awake link
  assign link_up = (state_q == uac_pkg::UAC_ST_RUN) && profile_default;
  assign out_free = !link_tx_valid || link_tx_ready;
  assign fifo_pop = fifo_valid && link_up && out_free;

  // buffered transmit stream toward the device link
  uac_fifo #(
    .WIDTH(`UAC_DATA_W),
    .DEPTH(`UAC_FIFO_DEPTH),
    .AW(`UAC_FIFO_AW)
  ) u_tx_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .clear(state_q == uac_pkg::UAC_ST_OFF),
    .in_data(user_tx_data),
    .in_valid(user_tx_valid),
    .in_ready(user_tx_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // output register toward the high speed device link
  always_ff @(posedge clock) begin
    if (sys_rst || state_q == uac_pkg::UAC_ST_OFF) begin
      link_tx_valid <= 1'b0;
      link_tx_data <= '0;
    end else if (out_free) begin
      link_tx_valid <= fifo_pop;
      if (fifo_pop) begin
        link_tx_data <= fifo_data;
      end
    end
  end
endmodule : uac_attach_ctl

// ### verif/uac_attach_ctl_checker.sv
`timescale 1ns/1ps
module uac_attach_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic bus_supply_sense,
  input wire logic host_select,
  input wire logic port_disabled,
  input wire logic power_saving_setting,
  input wire logic [7:0] link_tx_data,
  input wire logic link_tx_valid,
  input wire logic link_tx_ready,
  input wire logic usb_enable,
  input wire logic interchip_mode,
  input wire logic profile_default,
  input wire logic [2:0] acm_port_count,
  input wire logic suspended,
  input wire logic low_power_idle,
  input wire logic resume_drive,
  input wire logic interchip_ddr_data_oe_n,
  input wire logic interchip_strobe_oe_n,
  input wire logic others_power_saving
);
  logic [8:0] gone_q;
  // counts cycles with both sensed pins low
  always_ff @(posedge clock) begin
    if (sys_rst || bus_supply_sense || host_select) gone_q <= 9'h0;
    else if (gone_q != 9'h1ff) gone_q <= gone_q + 9'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_detach_when_low: assert property (gone_q > 9'h108 |-> !usb_enable)
    else $error("interface stays on without sensed pins");
  a_ports_match: assert property
    (acm_port_count == (profile_default ? 3'h6 : 3'h0))
    else $error("port count disagrees with profile");
  a_profile_attached: assert property (profile_default |-> usb_enable)
    else $error("default profile while detached");
  a_idle_suspended: assert property (low_power_idle |->
    usb_enable && (suspended || $past(suspended)))
    else $error("low power idle outside suspend");
  a_resume_usb: assert property (resume_drive |->
    suspended && !interchip_mode && interchip_ddr_data_oe_n)
    else $error("resume drive out of place");
  a_oe_pair: assert property
    (interchip_ddr_data_oe_n == interchip_strobe_oe_n)
    else $error("data and strobe enables differ");
  a_oe_interchip: assert property (!interchip_ddr_data_oe_n |->
    interchip_mode && suspended)
    else $error("inter-chip pins driven out of wake");
  a_others_track: assert property ($changed(power_saving_setting) |=>
    others_power_saving == $past(power_saving_setting))
    else $error("saving setting not passed on");
  a_susp_on_port: assert property (port_disabled && usb_enable &&
    !suspended |-> ##[1:3] (suspended || !usb_enable))
    else $error("no suspend on disabled port");
  a_link_hold: assert property (link_tx_valid && !link_tx_ready |=>
    !usb_enable || (link_tx_valid && $stable(link_tx_data)))
    else $error("link byte dropped while stalled");
endmodule : uac_attach_checker

bind uac_attach_ctl uac_attach_checker i_uac_attach_checker (.clock,
  .sys_rst, .bus_supply_sense, .host_select, .port_disabled,
  .power_saving_setting, .link_tx_data, .link_tx_valid, .link_tx_ready,
  .usb_enable, .interchip_mode, .profile_default, .acm_port_count,
  .suspended, .low_power_idle, .resume_drive, .interchip_ddr_data_oe_n,
  .interchip_strobe_oe_n, .others_power_saving);

// ### verif/uac_host_model.sv
`timescale 1ns/1ps
module uac_host_model (
  input wire logic clock,
  input wire logic stall,
  input wire logic [7:0] link_tx_data,
  input wire logic link_tx_valid,
  output logic link_tx_ready
);
  logic [7:0] got[$];
  initial link_tx_ready = 1'b0;
  // host side sink, ready follows the stall request after the edge
  always @(posedge clock) begin
    link_tx_ready <= !stall;
    if (link_tx_valid && link_tx_ready) got.push_back(link_tx_data);
  end
endmodule : uac_host_model

// ### verif/test_usb_device_attach_suspend_control.sv
`timescale 1ns/1ps
module test_usb_device_attach_suspend_control;
  logic clock, sys_rst, bus_supply_sense, host_select, stall;
  logic interchip_ddr_data_in, interchip_strobe_in, line_activity;
  logic port_disabled, profile_switch, remote_wake_allowed, wake_event;
  logic power_saving_setting, user_tx_valid, user_tx_ready, link_tx_valid;
  logic link_tx_ready, usb_enable, interchip_mode, profile_default;
  logic suspended, low_power_idle, resume_drive, others_power_saving;
  logic interchip_ddr_data_out, interchip_strobe_out;
  logic interchip_ddr_data_oe_n, interchip_strobe_oe_n;
  logic [7:0] user_tx_data, link_tx_data;
  logic [2:0] acm_port_count;
  int n_mismatch, n_compared, i, k;
  // byte sent beside the byte the host must see
  logic [15:0] rows [10] = '{16'h0000, 16'hffff, 16'h0101, 16'h8080,
    16'h5a5a, 16'ha5a5, 16'h7e7e, 16'h8181, 16'h3333, 16'hcccc};

  uac_attach_ctl #(.SUSP_IDLE_CYC(40), .RWAKE_MIN_CYC(60),
    .RESUME_CYC(20)) i_uac_attach_ctl (.*);
  uac_host_model i_uac_host_model (.clock, .stall, .link_tx_data,
    .link_tx_valid, .link_tx_ready);

  always #2 clock = ~clock;

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic ticks(input int n);
    repeat (n) @(negedge clock);
  endtask : ticks

  // offers a byte once ready shows, leaves valid up
  task automatic send(input logic [7:0] d);
    for (int w = 0; w < 50 && user_tx_ready !== 1'b1; w++) ticks(1);
    user_tx_data = d;
    user_tx_valid = 1'b1;
    ticks(1);
  endtask : send

  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // cuts a hang short
  initial begin
    #40000;
    n_mismatch++;
    results;
  end

  // main sequence
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    {bus_supply_sense, host_select, interchip_ddr_data_in, stall,
      interchip_strobe_in, port_disabled, profile_switch, wake_event,
      remote_wake_allowed, power_saving_setting, user_tx_valid} = '0;
    line_activity = 1'b1;
    user_tx_data = 8'h00;
    ticks(20);
    sys_rst = 1'b0;
    chk_bit(usb_enable, 1'b0);
    chk_bit(interchip_ddr_data_oe_n, 1'b1);
    $display("test reset done");
    bus_supply_sense = 1'b1;
    ticks(200);
    chk_bit(usb_enable, 1'b0);
    for (k = 0; k < 100 && usb_enable !== 1'b1; k++) ticks(1);
    chk_bit(usb_enable, 1'b1);
    chk_bit(interchip_mode, 1'b0);
    chk_byte({5'h0, acm_port_count}, 8'h00);
    send(8'h11);
    user_tx_valid = 1'b0;
    ticks(5);
    chk_bit(link_tx_valid, 1'b0);
    profile_switch = 1'b1;
    ticks(1);
    profile_switch = 1'b0;
    ticks(2);
    chk_bit(profile_default, 1'b1);
    chk_byte({5'h0, acm_port_count}, 8'h06);
    $display("test profile done");
    ticks(5);
    stall = 1'b1;
    ticks(2);
    for (i = 0; i < 10 && user_tx_ready === 1'b1; i++) send(rows[i][15:8]);
    user_tx_valid = 1'b0;
    chk_bit(user_tx_ready, 1'b0);
    chk_byte(link_tx_data, rows[0][7:0]);
    stall = 1'b0;
    for (; i < 10; i++) send(rows[i][15:8]);
    user_tx_valid = 1'b0;
    ticks(20);
    chk_byte(8'(i_uac_host_model.got.size()), 8'h0b);
    chk_byte(i_uac_host_model.got[0], 8'h11);
    for (i = 0; i < 10; i++) begin
      chk_byte(i_uac_host_model.got[i + 1], rows[i][7:0]);
    end
    $display("test stream done");
    line_activity = 1'b0;
    power_saving_setting = 1'b1;
    ticks(32);
    chk_bit(suspended, 1'b0);
    ticks(16);
    chk_bit(suspended, 1'b1);
    chk_byte({5'h0, acm_port_count}, 8'h06);
    chk_bit(low_power_idle, 1'b1);
    chk_bit(others_power_saving, 1'b1);
    line_activity = 1'b1;
    ticks(3);
    chk_bit(suspended, 1'b0);
    chk_bit(low_power_idle, 1'b0);
    port_disabled = 1'b1;
    ticks(3);
    chk_bit(suspended, 1'b1);
    port_disabled = 1'b0;
    ticks(3);
    chk_bit(suspended, 1'b0);
    $display("test suspend done");
    for (k = 0; k < 2; k++) begin
      line_activity = 1'b0;
      remote_wake_allowed = 1'b1;
      ticks(48);
      wake_event = 1'b1;
      ticks(1);
      wake_event = 1'b0;
      ticks(2);
      chk_bit(resume_drive, 1'b0);
      for (i = 0; i < 100 && resume_drive !== 1'b1 &&
        interchip_ddr_data_oe_n !== 1'b0; i++) ticks(1);
      chk_bit(resume_drive, k == 0);
      chk_bit(interchip_ddr_data_oe_n, k == 0);
      chk_bit(interchip_strobe_oe_n, k == 0);
      chk_bit(interchip_ddr_data_out, 1'b1);
      chk_bit(interchip_strobe_out, 1'b0);
      ticks(25);
      chk_bit(resume_drive, 1'b0);
      chk_bit(suspended, 1'b1);
      bus_supply_sense = 1'b0;
      host_select = 1'b0;
      ticks(200);
      chk_bit(usb_enable, 1'b1);
      for (i = 0; i < 100 && usb_enable !== 1'b0; i++) ticks(1);
      chk_bit(usb_enable, 1'b0);
      chk_bit(profile_default, 1'b0);
      $display("test wake and detach done");
      host_select = 1'b1;
      for (i = 0; i < 300 && usb_enable !== 1'b1; i++) ticks(1);
      chk_bit(interchip_mode, 1'b1);
    end
    ticks(45);
    chk_bit(suspended, 1'b1);
    interchip_strobe_in = 1'b1;
    ticks(5);
    chk_bit(suspended, 1'b0);
    power_saving_setting = 1'b0;
    ticks(45);
    chk_bit(suspended, 1'b1);
    chk_bit(low_power_idle, 1'b0);
    chk_bit(others_power_saving, 1'b0);
    interchip_ddr_data_in = 1'b1;
    ticks(5);
    chk_bit(suspended, 1'b0);
    $display("test inter-chip activity done");
    results;
  end
endmodule : test_usb_device_attach_suspend_control
